// File: logic/memctrl_global_control_status.sv
// Global control, status and configuration registers of the memory controller
// Summary of operation
// - Control bit 0 enables the controller; resets to 1 on both resets.
// - Disabled controller does no refresh; leaves it by enable write or reset.
// - Control bit 2 selects low-power, resets 0; refresh continues in low-power.
// - Low-power ends when software clears the bit or on either reset.
// - Control bit 1 reset map mirrors chip select 1 onto 0 and 4.
// - Memory accesses while low-power or disabled get an error response.
// - Register port stays fully usable in low-power or disabled state.
// - Control register writable in normal operation, zero wait states.
// - Control upper bits read undefined here zero; software writes zeros.
// - Status is read-only, zero wait states, upper bits read as zero.
// - Status bit 2 mirrors self-refresh acknowledge; resets to 1 on power-on.
// - Status bit 1 shows write buffers hold data; resets to 0.
// - Status bit 0 shows busy or self-refresh; resets to 1.
// - Configuration register accesses take exactly one wait state.
// - Configuration bit 8 selects clock ratio 1:1 (reset) or 1:2.
// - Configuration bit 0 endian; strap on power-on, writable, kept on bus reset.
`timescale 1ns/1ns
`default_nettype none

module memctrl_global_control_status
	import memctrl_regs_pkg::*;
(
	// Clock and resets
	input wire logic clock,
	input wire logic resetn,
	input wire logic power_on_reset_n,
	// Register programming port
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Memory side status
	input wire logic self_refresh_acknowledge,
	input wire logic write_buffer_pending,
	input wire logic controller_busy,
	input wire logic endian_strap_input,
	// Memory access gate and chip select map
	input wire logic mem_access_req,
	output logic mem_access_error,
	input wire logic [2:0] mem_cs_region,
	output logic [2:0] mem_cs_target,
	// Control outputs
	output logic controller_enable,
	output logic low_power_mode,
	output logic reset_map,
	output logic refresh_enable,
	output logic big_endian,
	output logic clock_ratio_half
);

	wire logic rst_all_n = resetn & power_on_reset_n;

	ctrl_s ctrl_q, ctrl_d;
	status_s status_q;
	logic enable_q, lowpower_q, busy_q;
	logic mirror_q, wbuf_q, sref_q;

	// Fields gathered from flops that sit in two reset domains
	assign ctrl_q = '{lowpower: lowpower_q, mirror: mirror_q, enable: enable_q};
	assign status_q = '{sref: sref_q, wbuf: wbuf_q, busy: busy_q};
	cfg_s cfg_q, cfg_d;
	phase_e ph_q, ph_d;
	logic write_q;
	logic [11:0] addr_q;
	logic [31:0] hrdata_q;
	logic strap_pend_q;
	logic [1:0] strap_cnt_q;
	logic strap_sync;

	memctrl_sync2 #(.WIDTH(1)) u_strap_sync (
		.clock(clock),
		.resetn(power_on_reset_n),
		.async_in(endian_strap_input),
		.sync_out(strap_sync)
	);

	// Address phase decode
	wire logic accept = hsel & hready & htrans[HTRANS_ACTIVE_BIT];
	wire logic [11:0] aoff = haddr[11:0];
	wire logic a_ctrl = aoff == CTRL_OFFSET;
	wire logic a_stat = aoff == STATUS_OFFSET;
	wire logic a_cfg = aoff == CONFIG_OFFSET;
	wire logic a_mapped = a_ctrl | a_stat | a_cfg;

	// Data phase decode
	wire logic do_write = (ph_q == PH_LAST) & write_q;
	wire logic w_ctrl = do_write & (addr_q == CTRL_OFFSET);
	wire logic w_cfg = do_write & (addr_q == CONFIG_OFFSET);
	wire logic strap_load = strap_pend_q & (strap_cnt_q == STRAP_SETTLE) & ~w_cfg;

	// Next state of the data phase
	always_comb begin
		ph_d = PH_IDLE;
		case (ph_q)
			PH_WAIT: ph_d = PH_LAST;
			PH_ERR: ph_d = PH_ERR_END;
			default: begin
				if (accept) begin
					if (!a_mapped) begin
						ph_d = PH_ERR;
					end else if (a_cfg) begin
						ph_d = PH_WAIT;
					end else begin
						ph_d = PH_LAST;
					end
				end
			end
		endcase
	end

	// Register next values; enable and low-power only change by write or reset
	assign ctrl_d.enable = w_ctrl ? hwdata[CTRL_ENABLE_BIT] : ctrl_q.enable;
	assign ctrl_d.mirror = w_ctrl ? hwdata[CTRL_MIRROR_BIT] : ctrl_q.mirror;
	assign ctrl_d.lowpower = w_ctrl ? hwdata[CTRL_LOWPOWER_BIT] :
		ctrl_q.lowpower;
	assign cfg_d.ratio = w_cfg ? hwdata[CFG_RATIO_BIT] : cfg_q.ratio;
	assign cfg_d.endian = w_cfg ? hwdata[CFG_ENDIAN_BIT] :
		(strap_load ? strap_sync : cfg_q.endian);

	// Control and configuration read data from next values so a read right after a write sees it
	logic [31:0] rd_word;
	always_comb begin
		rd_word = '0;
		if (a_ctrl) begin
			rd_word[CTRL_ENABLE_BIT] = ctrl_d.enable;
			rd_word[CTRL_MIRROR_BIT] = ctrl_d.mirror;
			rd_word[CTRL_LOWPOWER_BIT] = ctrl_d.lowpower;
		end else if (a_stat) begin
			rd_word[STAT_BUSY_BIT] = status_q.busy;
			rd_word[STAT_WBUF_BIT] = status_q.wbuf;
			rd_word[STAT_SREF_BIT] = status_q.sref;
		end else if (a_cfg) begin
			rd_word[CFG_ENDIAN_BIT] = cfg_d.endian;
			rd_word[CFG_RATIO_BIT] = cfg_d.ratio;
		end
	end

	// Bus state, cleared by either reset
	always_ff @(posedge clock or negedge rst_all_n) begin
		if (!rst_all_n) begin
			ph_q <= PH_IDLE;
			write_q <= 1'h0;
			addr_q <= '0;
			hrdata_q <= '0;
		end else begin
			ph_q <= ph_d;
			if (accept) begin
				write_q <= hwrite;
				addr_q <= aoff;
				hrdata_q <= hwrite ? hrdata_q : rd_word;
			end
		end
	end

	// Enable and low-power bits reset on either reset
	always_ff @(posedge clock or negedge rst_all_n) begin
		if (!rst_all_n) begin
			enable_q <= CTRL_ENABLE_RST;
			lowpower_q <= CTRL_LOWPOWER_RST;
			busy_q <= STAT_BUSY_RST;
		end else begin
			enable_q <= ctrl_d.enable;
			lowpower_q <= ctrl_d.lowpower;
			busy_q <= controller_busy | self_refresh_acknowledge;
		end
	end

	// Power-on only state
	always_ff @(posedge clock or negedge power_on_reset_n) begin
		if (!power_on_reset_n) begin
			mirror_q <= CTRL_MIRROR_RST;
			cfg_q.ratio <= CFG_RATIO_RST;
			cfg_q.endian <= CFG_ENDIAN_RST;
			wbuf_q <= STAT_WBUF_RST;
			sref_q <= STAT_SREF_RST;
			strap_pend_q <= 1'h1;
			strap_cnt_q <= '0;
		end else begin
			mirror_q <= ctrl_d.mirror;
			cfg_q <= cfg_d;
			wbuf_q <= write_buffer_pending;
			sref_q <= self_refresh_acknowledge;
			strap_pend_q <= strap_pend_q & ~strap_load & ~w_cfg;
			strap_cnt_q <= (strap_cnt_q == STRAP_SETTLE) ? strap_cnt_q : strap_cnt_q + 2'h1;
		end
	end

	// Bus answer
	assign hreadyout = (ph_q != PH_WAIT) & (ph_q != PH_ERR);
	assign hresp = ((ph_q == PH_ERR) | (ph_q == PH_ERR_END)) ? HRESP_ERROR : HRESP_OKAY;
	assign hrdata = hrdata_q;

	// Memory side controls
	wire logic mem_blocked = ~ctrl_q.enable | ctrl_q.lowpower;
	wire logic cs_mirrored = (mem_cs_region == CS_MIRROR_A) | (mem_cs_region == CS_MIRROR_B);
	assign mem_access_error = mem_access_req & mem_blocked;
	assign mem_cs_target = (ctrl_q.mirror & cs_mirrored) ? CS_MIRROR_SRC :
		mem_cs_region;
	assign refresh_enable = ctrl_q.enable;
	assign controller_enable = ctrl_q.enable;
	assign low_power_mode = ctrl_q.lowpower;
	assign reset_map = ctrl_q.mirror;
	assign big_endian = cfg_q.endian;
	assign clock_ratio_half = cfg_q.ratio;

	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_all_n);

	ctrl_zero_wait_a: assert property (accept && a_ctrl
		|=> hreadyout && hresp == HRESP_OKAY)
		else $error("control access waited");
	stat_zero_wait_a: assert property (accept && a_stat && mem_blocked
		|=> hreadyout && !hresp)
		else $error("status access waited or failed while blocked");
	cfg_one_wait_a: assert property (accept && a_cfg
		|=> !hreadyout ##1 hreadyout && !hresp)
		else $error("configuration access not one wait state");
	refresh_off_a: assert property ((w_ctrl ? !hwdata[CTRL_ENABLE_BIT]
		: !controller_enable) |=> !controller_enable && !refresh_enable)
		else $error("refresh continued while disabled");
	lowpower_refresh_a: assert property (low_power_mode
		&& controller_enable |-> refresh_enable)
		else $error("refresh stopped in low-power");
	lowpower_clear_a: assert property (w_ctrl && !hwdata[CTRL_LOWPOWER_BIT]
		|=> !low_power_mode)
		else $error("low-power not left");
	access_error_a: assert property (mem_access_req
		&& (!controller_enable || low_power_mode) |-> mem_access_error)
		else $error("blocked memory access not refused");
	mirror_map_a: assert property (reset_map && mem_cs_region == CS_MIRROR_B
		|-> mem_cs_target == CS_MIRROR_SRC)
		else $error("reset map not mirrored");
	sref_status_a: assert property (accept && a_stat && !hwrite
		&& $past(power_on_reset_n) |=> hrdata[STAT_SREF_BIT] == $past(self_refresh_acknowledge, 2))
		else $error("self-refresh status wrong");
	wbuf_status_a: assert property (accept && a_stat && !hwrite
		&& $past(power_on_reset_n) |=> hrdata[STAT_WBUF_BIT] == $past(write_buffer_pending, 2))
		else $error("write buffer status wrong");
	upper_zero_a: assert property (accept && a_ctrl && !hwrite |=> hrdata[31:3] == '0)
		else $error("control upper bits not zero");
	unmapped_err_a: assert property (accept && !a_mapped
		|=> !hreadyout && hresp ##1 hreadyout && hresp)
		else $error("unmapped access not two-cycle error");

	cfg_write_c: cover property (accept && a_cfg && hwrite ##2 w_cfg);
	disable_c: cover property (w_ctrl && !hwdata[CTRL_ENABLE_BIT] ##1 mem_access_req);
	lowpower_c: cover property ($rose(low_power_mode) ##[1:4] accept);
	unmapped_c: cover property (accept && !a_mapped);

endmodule

`default_nettype wire

// File: logic/memctrl_regs_pkg.sv
// Register map, field layout, reset values and types of the controller register group
package memctrl_regs_pkg;

	// Register offsets within the register programming port
	localparam logic [11:0] CTRL_OFFSET = 12'h000;
	localparam logic [11:0] STATUS_OFFSET = 12'h004;
	localparam logic [11:0] CONFIG_OFFSET = 12'h008;

	// Field positions
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_MIRROR_BIT = 1;
	localparam int CTRL_LOWPOWER_BIT = 2;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_WBUF_BIT = 1;
	localparam int STAT_SREF_BIT = 2;
	localparam int CFG_ENDIAN_BIT = 0;
	localparam int CFG_RATIO_BIT = 8;

	// Reset values
	localparam logic CTRL_ENABLE_RST = 1'h1;
	localparam logic CTRL_MIRROR_RST = 1'h1;
	localparam logic CTRL_LOWPOWER_RST = 1'h0;
	localparam logic STAT_BUSY_RST = 1'h1;
	localparam logic STAT_WBUF_RST = 1'h0;
	localparam logic STAT_SREF_RST = 1'h1;
	localparam logic CFG_RATIO_RST = 1'h0;
	localparam logic CFG_ENDIAN_RST = 1'h0;

	// Strap capture waits for the two synchroniser stages
	localparam logic [1:0] STRAP_SETTLE = 2'h2;

	// Bus encodings
	localparam int HTRANS_ACTIVE_BIT = 1;
	localparam logic HRESP_OKAY = 1'h0;
	localparam logic HRESP_ERROR = 1'h1;

	// Chip select regions involved in the reset memory map
	localparam logic [2:0] CS_MIRROR_SRC = 3'h1;
	localparam logic [2:0] CS_MIRROR_A = 3'h0;
	localparam logic [2:0] CS_MIRROR_B = 3'h4;

	typedef struct packed {
		logic lowpower;
		logic mirror;
		logic enable;
	} ctrl_s;

	typedef struct packed {
		logic sref;
		logic wbuf;
		logic busy;
	} status_s;

	typedef struct packed {
		logic ratio;
		logic endian;
	} cfg_s;

	typedef enum logic [2:0] {
		PH_IDLE = 3'b000,
		PH_LAST = 3'b001,
		PH_WAIT = 3'b010,
		PH_ERR = 3'b011,
		PH_ERR_END = 3'b100
	} phase_e;

endpackage

// File: logic/memctrl_sync2.sv
// Two-stage synchroniser for inputs from outside the bus clock domain
`timescale 1ns/1ns
`default_nettype none

module memctrl_sync2 #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic clock,
	input wire logic resetn,
	// Data
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;

endmodule

`default_nettype wire

// File: testbench/memctrl_ahb_master.sv
// Bus master model for the register programming port
`timescale 1ns/1ns
`default_nettype none

module memctrl_ahb_master (
	// Clock
	input wire logic clock,
	// Request
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [31:0] hwdata,
	// Answer
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata
);
	initial begin
		hsel = 1'h0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'h0;
		hwdata = 32'h0;
	end

	// One transfer; released lines show inverted old values
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic rsp, output int waits);
		@(negedge clock);
		hsel = 1'h1;
		htrans = 2'h2;
		hwrite = wr;
		haddr = {20'h0, a};
		hwdata = ~hwdata;
		@(negedge clock);
		hsel = 1'h0;
		htrans = 2'h0;
		haddr = ~haddr;
		hwdata = wd;
		waits = 0;
		while (hreadyout !== 1'h1 && waits < 8) begin
			waits++;
			@(negedge clock);
		end
		rd = hrdata;
		rsp = hresp;
	endtask
endmodule

`default_nettype wire

// File: testbench/memctrl_global_control_status_bench.sv
// Self-checking bench for the controller control and status registers
`timescale 1ns/1ns
`default_nettype none

module memctrl_global_control_status_bench import memctrl_regs_pkg::*;;
	typedef struct {
		logic wr;
		logic [11:0] a;
		logic [31:0] wd;
		logic [31:0] rd;
		logic rsp;
		int w;
		logic [4:0] o;
	} row_s;

	logic clock = 1'h0;
	logic resetn = 1'h0;
	logic power_on_reset_n = 1'h0;
	logic sref = 1'h0;
	logic wbuf = 1'h0;
	logic busy = 1'h0;
	logic strap = 1'h1;
	logic req = 1'h1;
	logic [2:0] region = 3'h0;
	logic hsel, hwrite, hreadyout, hresp, gate_error, enable, low_power, map, refresh, endian, ratio;
	logic [1:0] htrans;
	logic [2:0] target;
	logic [31:0] haddr, hwdata, hrdata;
	int num_errors = 0;
	int samples_checked = 0;
	// Outputs: {ratio, endian, low power, map, enable}
	row_s rows[12] = '{
		'{1'h0, CTRL_OFFSET, 32'h0, 32'h3, 1'h0, 0, 5'h0B},
		'{1'h0, CONFIG_OFFSET, 32'h0, 32'h1, 1'h0, 1, 5'h0B},
		'{1'h1, CTRL_OFFSET, 32'h0, 32'h0, 1'h0, 0, 5'h08},
		'{1'h0, CTRL_OFFSET, 32'h0, 32'h0, 1'h0, 0, 5'h08},
		'{1'h1, CTRL_OFFSET, 32'h5, 32'h0, 1'h0, 0, 5'h0D},
		'{1'h0, CTRL_OFFSET, 32'h0, 32'h5, 1'h0, 0, 5'h0D},
		'{1'h1, CONFIG_OFFSET, 32'h100, 32'h0, 1'h0, 1, 5'h15},
		'{1'h0, CONFIG_OFFSET, 32'h0, 32'h100, 1'h0, 1, 5'h15},
		'{1'h1, STATUS_OFFSET, 32'hFFFFFFFF, 32'h0, 1'h0, 0, 5'h15},
		'{1'h0, STATUS_OFFSET, 32'h0, 32'h0, 1'h0, 0, 5'h15},
		'{1'h0, 12'h00C, 32'h0, 32'h0, 1'h1, 1, 5'h15},
		'{1'h1, CTRL_OFFSET, 32'h1, 32'h0, 1'h0, 0, 5'h11}
	};

	always #5 clock = ~clock;

	memctrl_global_control_status i_memctrl_global_control_status (
		.clock(clock), .resetn(resetn), .power_on_reset_n(power_on_reset_n),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .self_refresh_acknowledge(sref), .write_buffer_pending(wbuf),
		.controller_busy(busy), .endian_strap_input(strap), .mem_access_req(req),
		.mem_access_error(gate_error), .mem_cs_region(region), .mem_cs_target(target),
		.controller_enable(enable), .low_power_mode(low_power), .reset_map(map),
		.refresh_enable(refresh), .big_endian(endian), .clock_ratio_half(ratio)
	);

	memctrl_ahb_master i_memctrl_ahb_master (
		.clock(clock), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata)
	);

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop;
		$display("Checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		input logic [31:0] erd, input logic ersp, input int ew);
		logic [31:0] rd;
		logic rsp;
		int w;
		i_memctrl_ahb_master.xfer(wr, a, wd, rd, rsp, w);
		check("response", {31'h0, rsp}, {31'h0, ersp});
		check("wait states", 32'(w), 32'(ew));
		if (!wr && !ersp) check("read data", rd, erd);
	endtask

	task automatic do_reset(input logic por);
		@(negedge clock);
		resetn = 1'h0;
		power_on_reset_n = ~por;
		repeat (3) @(negedge clock);
		resetn = 1'h1;
		power_on_reset_n = 1'h1;
		repeat (3) @(negedge clock);
	endtask

	task automatic cs_check(input logic m);
		for (int r = 0; r < 8; r++) begin
			@(negedge clock);
			region = 3'(r);
			@(posedge clock);
			check("target", {29'h0, target},
				{29'h0, (m && (r == 0 || r == 4)) ? 3'h1 : 3'(r)});
		end
	endtask

	initial begin
		do_reset(1'h1);
		foreach (rows[i]) begin
			bus(rows[i].wr, rows[i].a, rows[i].wd, rows[i].rd, rows[i].rsp, rows[i].w);
			@(negedge clock);
			check("outputs",
				{27'h0, ratio, endian, low_power, map, enable}, {27'h0, rows[i].o});
			check("gate",
				{30'h0, gate_error, refresh}, {30'h0, rows[i].o[2] | ~rows[i].o[0], rows[i].o[0]});
		end
		for (int v = 0; v < 8; v++) begin
			{sref, wbuf, busy} = 3'(v);
			bus(1'h0, STATUS_OFFSET, 32'h0,
				{29'h0, v[2], v[1], v[0] | v[2]}, 1'h0, 0);
		end
		{sref, wbuf, busy} = 3'h0;
		cs_check(1'h0);
		// Mode change made while status reports idle
		bus(1'h1, CTRL_OFFSET, 32'h4, 32'h0, 1'h0, 0);
		do_reset(1'h0);
		bus(1'h0, CTRL_OFFSET, 32'h0, 32'h1, 1'h0, 0);
		bus(1'h0, CONFIG_OFFSET, 32'h0, 32'h100, 1'h0, 1);
		do_reset(1'h1);
		bus(1'h0, CTRL_OFFSET, 32'h0, 32'h3, 1'h0, 0);
		bus(1'h0, CONFIG_OFFSET, 32'h0, 32'h1, 1'h0, 1);
		cs_check(1'h1);
		report_and_stop;
	end

	initial begin
		#200000;
		num_errors++;
		report_and_stop;
	end
endmodule

`default_nettype wire
